// >>> hdl/dmx_map.vh
`ifndef DMX_MAP_VH
`define DMX_MAP_VH
`define DMX_Q1 4'h1
`define DMX_Q2 4'h2
`define DMX_Q3 4'h4
`define DMX_Q4 4'h8
`define DMX_OP_COPY 6'h08
`define DMX_OP_HI_ZERO 6'h00
`define DMX_LIT_TOP 4'hC
`define DMX_W_RESET 8'h00
`define DMX_Z_RESET 1'h0
`define DMX_IR_RESET 14'h0000
`define DMX_ADDR_RESET 7'h00
`define DMX_DATA_RESET 8'h00
`define DMX_FA_MSB 6
`define DMX_D_BIT 7
`define DMX_STORE_BIT 7
`endif

// >>> hdl/dmx_decode.v
`timescale 1ns/1ns
`include "dmx_map.vh"
module dmx_decode
(
  // Instruction word.
  input wire [13:0] instr,
  // Decoded class.
  output reg is_lit,
  output reg is_copy,
  output reg is_store,
  output reg is_idle
);
  always @*
  begin
    is_lit = (instr[13:10] == `DMX_LIT_TOP);
    is_copy = (instr[13:8] == `DMX_OP_COPY);
    is_store = (instr[13:8] == `DMX_OP_HI_ZERO) && instr[`DMX_STORE_BIT];
    // The two don't-care bits are masked so every legal variant decodes alike.
    is_idle = (instr[13:8] == `DMX_OP_HI_ZERO) && (instr[7] == 1'b0) && (instr[4:0] == 5'h00);
  end
endmodule

// >>> hdl/dmx_exec.v
`timescale 1ns/1ns
`include "dmx_map.vh"
// Function
// - Load literal puts the eight-bit immediate into the accumulator.
// - Copy instruction reads the file register at the seven-bit address.
// - Copy with destination bit 0 writes the value to the accumulator.
// - Copy with destination bit 1 writes the value back to the register.
// - Copy updates the zero flag from the moved value, either destination.
// - Copy: decode in Q1, read in Q2, destination written as Q3 ends.
// - Idle instruction changes no register or flag in any phase.
// - Idle decodes from 00 0000 0xx00000, ignoring the don't-care bits.
module dmx_exec
(
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Program memory.
  input wire [13:0] instr,
  output reg fetch_r,
  // File register array.
  output reg [6:0] file_addr_r,
  input wire [7:0] file_rdata,
  output reg [7:0] file_wdata_r,
  output reg file_we_r,
  // Core state.
  output reg [7:0] acc_r,
  output reg zero_r,
  output reg [3:0] phase_r
);
  // One-hot phases of the instruction cycle.
  localparam [3:0] PH_Q1 = `DMX_Q1;
  localparam [3:0] PH_Q2 = `DMX_Q2;
  localparam [3:0] PH_Q3 = `DMX_Q3;
  localparam [3:0] PH_Q4 = `DMX_Q4;

  wire is_lit;
  wire is_copy;
  wire is_store;
  wire is_idle;
  wire quiet;
  wire copy_to_acc;
  wire copy_to_file;
  wire moved_zero;
  reg [13:0] ir_r;
  reg [13:0] ir_nxt;
  reg [7:0] data_r;
  reg [7:0] data_nxt;
  reg [3:0] phase_nxt;
  reg fetch_nxt;
  reg [6:0] file_addr_nxt;
  reg [7:0] file_wdata_nxt;
  reg file_we_nxt;
  reg [7:0] acc_nxt;
  reg zero_nxt;

  dmx_decode i_dmx_decode
  (
    .instr(ir_r),
    .is_lit(is_lit),
    .is_copy(is_copy),
    .is_store(is_store),
    .is_idle(is_idle)
  );

  // Idle and every word outside this subset share one quiet path that touches nothing.
  assign quiet = is_idle | ~(is_lit | is_copy | is_store);
  assign copy_to_acc = is_copy & ~ir_r[`DMX_D_BIT];
  assign copy_to_file = is_copy & ir_r[`DMX_D_BIT];
  assign moved_zero = (data_r == 8'h00);

  always @*
  begin
    case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
      // A corrupted phase recovers to Q1 rather than stalling the core.
      default: phase_nxt = PH_Q1;
    endcase
  end

  // The word and its address are taken as Q4 ends, so Q1 decodes a word that no longer moves.
  always @*
  begin
    fetch_nxt = (phase_nxt == PH_Q4);
    ir_nxt = ir_r;
    file_addr_nxt = file_addr_r;
    case (phase_r)
      PH_Q4:
      begin
        ir_nxt = instr;
        file_addr_nxt = instr[`DMX_FA_MSB:0];
      end
      default:
      begin
        ir_nxt = ir_r;
      end
    endcase
  end

  // Operands are read as Q2 ends, two full phases after the address settles, which gives the file
  // array its access time.
  always @*
  begin
    data_nxt = data_r;
    case (phase_r)
      PH_Q2:
      begin
        if (is_copy)
        begin
          data_nxt = file_rdata;
        end
        else if (is_lit)
        begin
          data_nxt = ir_r[7:0];
        end
        else if (is_store)
        begin
          data_nxt = acc_r;
        end
        else
        begin
          data_nxt = data_r;
        end
      end
      default:
      begin
        data_nxt = data_r;
      end
    endcase
  end

  // Destinations change as Q3 ends, so the write pulse and the new flag stand through Q4.
  always @*
  begin
    file_we_nxt = 1'b0;
    file_wdata_nxt = file_wdata_r;
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    case (phase_r)
      PH_Q3:
      begin
        if (!quiet)
        begin
          if (copy_to_file)
          begin
            file_wdata_nxt = data_r;
            file_we_nxt = 1'b1;
          end
          if (copy_to_acc)
          begin
            acc_nxt = data_r;
          end
          if (is_copy)
          begin
            zero_nxt = moved_zero;
          end
          // Store and load literal leave the zero flag alone.
          if (is_store)
          begin
            file_wdata_nxt = data_r;
            file_we_nxt = 1'b1;
          end
          if (is_lit)
          begin
            acc_nxt = data_r;
          end
        end
      end
      default:
      begin
        file_we_nxt = 1'b0;
      end
    endcase
  end

  // Reset parks the core in Q4 so the first edge after release takes the first word.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase_r <= `DMX_Q4;
      fetch_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ir_r <= `DMX_IR_RESET;
      file_addr_r <= `DMX_ADDR_RESET;
    end
    else
    begin
      ir_r <= ir_nxt;
      file_addr_r <= file_addr_nxt;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      data_r <= `DMX_DATA_RESET;
    end
    else
    begin
      data_r <= data_nxt;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      file_we_r <= 1'b0;
      file_wdata_r <= `DMX_DATA_RESET;
      acc_r <= `DMX_W_RESET;
      zero_r <= `DMX_Z_RESET;
    end
    else
    begin
      file_we_r <= file_we_nxt;
      file_wdata_r <= file_wdata_nxt;
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end
endmodule

// >>> testbench/dmx_props.sv
`timescale 1ns/1ns
module dmx_props
(
  // Clock and reset.
  input logic mclk,
  input logic rst,
  // Program memory.
  input logic [13:0] instr,
  input logic fetch_r,
  // File register array.
  input logic [6:0] file_addr_r,
  input logic [7:0] file_rdata,
  input logic [7:0] file_wdata_r,
  input logic file_we_r,
  // Core state.
  input logic [7:0] acc_r,
  input logic zero_r,
  input logic [3:0] phase_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Results are judged one full cycle after the word is taken.
  wire q4 = phase_r == 4'h8;
  lit_load_a: assert property (q4 && instr[13:10] == 4'hC |-> ##4
    acc_r == $past(instr[7:0], 4) && zero_r == $past(zero_r, 4) && !file_we_r) else $error("bad literal");
  copy_acc_a: assert property (q4 && instr[13:7] == 7'h10 |-> ##4
    acc_r == $past(file_rdata, 2) && zero_r == ($past(file_rdata, 2) == 8'h00) && !file_we_r) else $error("bad copy");
  copy_back_a: assert property (q4 && instr[13:7] == 7'h11 |-> ##4 file_we_r &&
    file_wdata_r == $past(file_rdata, 2) && zero_r == (file_wdata_r == 8'h00)) else $error("bad copy back");
  store_acc_a: assert property (q4 && instr[13:7] == 7'h01 |-> ##4 file_we_r &&
    file_wdata_r == $past(acc_r, 4) && zero_r == $past(zero_r, 4)) else $error("bad store");
  idle_hold_a: assert property (q4 && instr[13:7] == 7'h00 && instr[4:0] == 5'h00 |-> ##4
    !file_we_r && acc_r == $past(acc_r, 4) && zero_r == $past(zero_r, 4)) else $error("idle changed state");
  write_q4_a: assert property (file_we_r |-> q4) else $error("write off phase");
  fetch_q4_a: assert property (phase_r == 4'h4 |=> fetch_r && q4) else $error("bad fetch");
  addr_take_a: assert property (q4 |=> file_addr_r == $past(instr[6:0])) else $error("bad address");
endmodule
bind dmx_exec dmx_props i_dmx_props (.mclk, .rst, .instr, .fetch_r, .file_addr_r, .file_rdata,
  .file_wdata_r, .file_we_r, .acc_r, .zero_r, .phase_r);

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  reg mclk = 0, rst = 1;
  reg [13:0] instr = 14'h0000;
  reg [7:0] mem [0:127];
  wire [6:0] fa;
  wire [7:0] wd, acc;
  wire we, z;
  wire [3:0] ph;
  integer n_fail = 0, comparisons = 0, i;
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (we) mem[fa] <= wd;
  dmx_exec i_dmx_exec (.mclk(mclk), .rst(rst), .instr(instr), .fetch_r(), .file_addr_r(fa), .file_rdata(mem[fa]),
    .file_wdata_r(wd), .file_we_r(we), .acc_r(acc), .zero_r(z), .phase_r(ph));
  task test_done;
  begin
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input [8:0] g, e);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  end
  endtask
  // Presents one word at Q4 and returns at the next Q4, accumulator and flag settled; a file write lands one edge later.
  task ex(input [13:0] w);
  begin
    for (i = 0; i < 8 && ph !== 4'h8; i = i + 1) @(posedge mclk) #1;
    if (ph !== 4'h8)
    begin
      n_fail = n_fail + 1;
      test_done;
    end
    instr = w;
    repeat (4) @(posedge mclk) #1;
  end
  endtask
  task t_copy;
  begin
    mem[16] = 8'h00;
    mem[127] = 8'h3C;
    ex(14'h0810); chk({z, acc}, 9'h100);
    ex(14'h0060); chk({z, acc}, 9'h100);
    ex(14'h08FF); chk({z, acc}, 9'h000);
    ex(14'h0000); chk({1'h0, mem[127]}, 9'h03C);
  end
  endtask
  task t_lit;
  begin
    mem[16] = 8'h00;
    ex(14'h0810);
    ex(14'h33A5); chk({z, acc}, 9'h1A5);
    ex(14'h00C5); chk({z, acc}, 9'h1A5);
    ex(14'h0000); chk({1'h0, mem[69]}, 9'h0A5);
  end
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    #1 rst = 0;
    t_copy;
    t_lit;
    test_done;
  end
endmodule
